// ---- serial_boot_loader_link.sv ----
/*
 * Serial loader front end: async port with rate detection, sync slave port,
 * interface lock, packet framing, checksum and ACK/NAK reply.
 * Assumes clk_sys is the crystal clock and all pins are synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "loader_link_map.svh"
// Overview of operation
// - same byte stream and packet protocol accepted from async or sync port.
// - first interface used locks out the other until reset.
// - async characters are one start, eight data, no parity, one stop.
// - async divider never set below sixteen clocks per bit.
// - sync pattern edges timed on crystal clock set the async divider.
// - after good detection send one 0xCC at the new rate.
// - all timing derives from the crystal clock, no PLL.
// - sync port is fixed clock polarity one, clock phase one.
// - host is sync master and supplies clock; no detection there.
// - packet is length byte, sum byte, then data; sum is mod 256.
// - reply 0xCC for a good packet, 0x33 for a faulty one.
// - zero bytes before the first non-zero byte are dropped.
module serial_boot_loader_link (
	input wire logic clk_sys, // crystal clock
	input wire logic rst, // async reset, high
	input wire logic uartRx, // async receive line
	output var logic uartTx, // async transmit line
	input wire logic ssiClk, // sync clock from host
	input wire logic ssiFss_n, // sync frame select, low
	input wire logic ssiMosi, // sync data from host
	output var logic ssiMiso, // sync data to host
	output var logic ssiMisoOe, // miso drive enable
	output var loader_link_pkg::link_t linkSel, // locked interface
	output var logic [15:0] rateDivisor, // clocks per async bit
	output var loader_link_pkg::beat_t dataOut, // packet data bytes
	output var logic pktDone, // packet end pulse
	output var logic pktGood // last packet sum ok
);
	// ****************************************************************
	// line edges and rate measurement
	// ****************************************************************
	logic uartPrev, ssiClkPrev;
	logic [3:0] syncFalls;
	logic [20:0] syncCount;
	loader_link_pkg::async_t aState;
	logic [17:0] aTimer;
	logic [2:0] aBit;
	logic [7:0] aShift;
	logic asyncByte;
	logic txBusy;
	logic [3:0] txLeft;
	logic [15:0] txTimer;
	logic [8:0] txShift;
	logic [2:0] sBit;
	logic [7:0] sRxShift, sTxShift, ssiData, ssiPendByte;
	logic ssiByte, ssiPend, replyReq;
	logic [7:0] replyByte;
	loader_link_pkg::pkt_t pState;
	logic [7:0] pLeft, pSum, pExp;

	wire logic uartFall = uartPrev & ~uartRx;
	wire logic ssiRise = ~ssiClkPrev & ssiClk;
	wire logic ssiFall = ssiClkPrev & ~ssiClk;
	wire logic ssiActive = ~ssiFss_n && linkSel != loader_link_pkg::LINK_ASYNC;
	wire logic [20:0] syncNext = syncCount + 21'h0_0001;
	wire logic [15:0] newDiv = syncNext[`LL_DIV_MSB:`LL_DIV_LSB];
	// ninth falling edge closes sixteen bit times of the pattern
	wire logic syncOk = aState == loader_link_pkg::A_MEASURE
		&& linkSel == loader_link_pkg::LINK_NONE && uartFall
		&& syncFalls == `LL_SYNC_LAST && !syncNext[`LL_CNT_OVF]
		&& newDiv >= `LL_MIN_DIV;
	wire logic [17:0] skipLen = {1'b0, newDiv, 1'b0} + {2'b00, newDiv} + {3'b000, newDiv[15:1]};
	wire logic [17:0] bitLen = {2'b00, rateDivisor - 16'h0001};
	wire logic ssiDone = ssiActive && ssiRise && sBit == `LL_LAST_BIT;
	wire logic inValid = (asyncByte && linkSel == loader_link_pkg::LINK_ASYNC) || ssiByte;
	wire logic [7:0] inData = ssiByte ? ssiData : aShift;

	// edge history, idle levels after reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			uartPrev <= 1'b1;
			ssiClkPrev <= 1'b1;
		end else begin
			uartPrev <= uartRx;
			ssiClkPrev <= ssiClk;
		end
	end

	// interface lock, released only by reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			linkSel <= loader_link_pkg::LINK_NONE;
		end else if (linkSel == loader_link_pkg::LINK_NONE) begin
			if (syncOk) begin
				linkSel <= loader_link_pkg::LINK_ASYNC;
			end else if (ssiDone) begin
				linkSel <= loader_link_pkg::LINK_SYNC;
			end
		end
	end

	// ****************************************************************
	// async receiver with pattern measurement
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aState <= loader_link_pkg::A_MEASURE;
			syncFalls <= 4'h0;
			syncCount <= 21'h0_0000;
			aTimer <= 18'h0_0000;
			aBit <= 3'h0;
			aShift <= 8'h00;
			asyncByte <= 1'b0;
			rateDivisor <= 16'h0000;
		end else begin
			asyncByte <= 1'b0;
			unique case (aState)
			loader_link_pkg::A_MEASURE: begin
				if (linkSel != loader_link_pkg::LINK_NONE) begin
					syncFalls <= 4'h0;
				end else if (uartFall) begin
					if (syncFalls == 4'h0) begin
						syncFalls <= 4'h1;
						syncCount <= 21'h0_0000;
					end else if (syncOk) begin
						rateDivisor <= newDiv;
						aTimer <= skipLen;
						aState <= loader_link_pkg::A_SKIP;
					end else if (syncFalls == `LL_SYNC_LAST) begin
						syncFalls <= 4'h0;
					end else begin
						syncFalls <= syncFalls + 4'h1;
						syncCount <= syncNext;
					end
				end else if (syncFalls != 4'h0) begin
					syncCount <= syncNext;
					if (syncNext[`LL_CNT_OVF]) begin
						syncFalls <= 4'h0;
					end
				end
			end
			loader_link_pkg::A_SKIP: begin
				// ride out the tail of the second pattern byte
				aTimer <= aTimer - 18'h0_0001;
				if (aTimer == 18'h0_0000) begin
					aState <= loader_link_pkg::A_IDLE;
				end
			end
			loader_link_pkg::A_IDLE: begin
				if (uartFall) begin
					aTimer <= {3'b000, rateDivisor[15:1]};
					aState <= loader_link_pkg::A_START;
				end
			end
			loader_link_pkg::A_START: begin
				aTimer <= aTimer - 18'h0_0001;
				if (aTimer == 18'h0_0000) begin
					aTimer <= bitLen;
					aBit <= 3'h0;
					aState <= uartRx ? loader_link_pkg::A_IDLE : loader_link_pkg::A_DATA;
				end
			end
			loader_link_pkg::A_DATA: begin
				aTimer <= aTimer - 18'h0_0001;
				if (aTimer == 18'h0_0000) begin
					aShift <= {uartRx, aShift[7:1]};
					aBit <= aBit + 3'h1;
					aTimer <= bitLen;
					if (aBit == `LL_LAST_BIT) begin
						aState <= loader_link_pkg::A_STOP;
					end
				end
			end
			loader_link_pkg::A_STOP: begin
				aTimer <= aTimer - 18'h0_0001;
				if (aTimer == 18'h0_0000) begin
					asyncByte <= uartRx;
					aState <= loader_link_pkg::A_IDLE;
				end
			end
			endcase
		end
	end

	// ****************************************************************
	// async transmitter
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			uartTx <= 1'b1;
			txBusy <= 1'b0;
			txLeft <= 4'h0;
			txTimer <= 16'h0000;
			txShift <= 9'h1FF;
		end else if (syncOk || (replyReq && linkSel == loader_link_pkg::LINK_ASYNC)) begin
			uartTx <= 1'b0;
			txBusy <= 1'b1;
			txLeft <= `LL_TX_BITS;
			txTimer <= (syncOk ? newDiv : rateDivisor) - 16'h0001;
			txShift <= {1'b1, syncOk ? `LL_ACK_BYTE : replyByte};
		end else if (txBusy) begin
			txTimer <= txTimer - 16'h0001;
			if (txTimer == 16'h0000) begin
				txTimer <= rateDivisor - 16'h0001;
				if (txLeft != 4'h0) begin
					uartTx <= txShift[0];
					txShift <= {1'b1, txShift[8:1]};
					txLeft <= txLeft - 4'h1;
				end else begin
					txBusy <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// sync slave port, host clocked
	// ****************************************************************
	// sample on rising, drive on falling, idle clock high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sBit <= 3'h0;
			sRxShift <= 8'h00;
			sTxShift <= 8'h00;
			ssiMiso <= 1'b0;
			ssiMisoOe <= 1'b0;
			ssiByte <= 1'b0;
			ssiData <= 8'h00;
			ssiPend <= 1'b0;
			ssiPendByte <= 8'h00;
		end else begin
			ssiMisoOe <= ssiActive;
			ssiByte <= ssiDone && !syncOk;
			if (!ssiActive) begin
				sBit <= 3'h0;
			end else if (ssiRise) begin
				sRxShift <= {sRxShift[6:0], ssiMosi};
				sBit <= sBit + 3'h1;
				if (sBit == `LL_LAST_BIT) begin
					ssiData <= {sRxShift[6:0], ssiMosi};
				end
			end else if (ssiFall) begin
				if (sBit == 3'h0) begin
					ssiMiso <= ssiPend ? ssiPendByte[7] : 1'b0;
					sTxShift <= ssiPend ? {ssiPendByte[6:0], 1'b0} : `LL_PAD_BYTE;
					ssiPend <= 1'b0;
				end else begin
					ssiMiso <= sTxShift[7];
					sTxShift <= {sTxShift[6:0], 1'b0};
				end
			end
			if (replyReq && linkSel == loader_link_pkg::LINK_SYNC) begin
				ssiPend <= 1'b1;
				ssiPendByte <= replyByte;
			end
		end
	end

	// ****************************************************************
	// packet framing and reply
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pState <= loader_link_pkg::P_PAD;
			pLeft <= 8'h00;
			pSum <= 8'h00;
			pExp <= 8'h00;
			dataOut <= '0;
			pktDone <= 1'b0;
			pktGood <= 1'b0;
			replyReq <= 1'b0;
			replyByte <= `LL_NAK_BYTE;
		end else begin
			dataOut.valid <= 1'b0;
			pktDone <= 1'b0;
			replyReq <= 1'b0;
			if (inValid) begin
				unique case (pState)
				loader_link_pkg::P_PAD: begin
					pSum <= 8'h00;
					if (inData != `LL_PAD_BYTE && inData < `LL_LEN_MIN) begin
						pktDone <= 1'b1;
						pktGood <= 1'b0;
						replyReq <= 1'b1;
						replyByte <= `LL_NAK_BYTE;
					end else if (inData != `LL_PAD_BYTE) begin
						pLeft <= inData - `LL_LEN_MIN;
						pState <= loader_link_pkg::P_SUM;
					end
				end
				loader_link_pkg::P_SUM: begin
					pExp <= inData;
					if (pLeft == 8'h00) begin
						pktDone <= 1'b1;
						pktGood <= inData == 8'h00;
						replyReq <= 1'b1;
						replyByte <= inData == 8'h00 ? `LL_ACK_BYTE : `LL_NAK_BYTE;
						pState <= loader_link_pkg::P_PAD;
					end else begin
						pState <= loader_link_pkg::P_DATA;
					end
				end
				loader_link_pkg::P_DATA: begin
					dataOut <= '{valid: 1'b1, last: pLeft == 8'h01, data: inData};
					pSum <= pSum + inData;
					pLeft <= pLeft - 8'h01;
					if (pLeft == 8'h01) begin
						pktDone <= 1'b1;
						pktGood <= 8'(pSum + inData) == pExp;
						replyReq <= 1'b1;
						replyByte <= 8'(pSum + inData) == pExp ? `LL_ACK_BYTE : `LL_NAK_BYTE;
						pState <= loader_link_pkg::P_PAD;
					end
				end
				endcase
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_tx_quiet_idle: assert property (@(posedge clk_sys) disable iff (rst)
		!txBusy |-> uartTx) else $error("async line not idle high");
	chk_lock_held: assert property (@(posedge clk_sys) disable iff (rst)
		linkSel != loader_link_pkg::LINK_NONE |=> $stable(linkSel)) else $error("lock changed");
	chk_miso_locked_out: assert property (@(posedge clk_sys) disable iff (rst)
		linkSel == loader_link_pkg::LINK_ASYNC |=> !ssiMisoOe [*2]) else $error("miso driven");
	chk_div_floor: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(rateDivisor) |-> rateDivisor >= `LL_MIN_DIV) else $error("divider too small");
	chk_sync_ack_sent: assert property (@(posedge clk_sys) disable iff (rst)
		syncOk |=> txBusy && !uartTx && txShift[7:0] == `LL_ACK_BYTE
			&& rateDivisor == $past(newDiv)) else $error("sync ack not started");
	chk_stop_bit_end: assert property (@(posedge clk_sys) disable iff (rst)
		txBusy && txLeft == 4'h0 && txTimer == 16'h0000 && !replyReq |=> !txBusy && uartTx)
		else $error("frame not ended by stop");
	chk_reply_code: assert property (@(posedge clk_sys) disable iff (rst)
		pktDone |-> replyReq && ((replyByte == `LL_ACK_BYTE) == pktGood)) else $error("bad reply");
	chk_pad_dropped: assert property (@(posedge clk_sys) disable iff (rst)
		pState == loader_link_pkg::P_PAD && inValid && inData == `LL_PAD_BYTE
		|=> pState == loader_link_pkg::P_PAD && !pktDone && !dataOut.valid)
		else $error("pad byte taken");
	chk_sum_result: assert property (@(posedge clk_sys) disable iff (rst)
		pState == loader_link_pkg::P_DATA && inValid && pLeft == 8'h01
		|=> pktDone && pktGood == (8'($past(pSum) + $past(inData)) == $past(pExp)))
		else $error("checksum verdict wrong");
	chk_ssi_sample_rise: assert property (@(posedge clk_sys) disable iff (rst)
		ssiActive && ssiRise |=> sRxShift[0] == $past(ssiMosi)) else $error("mosi not sampled");
endmodule : serial_boot_loader_link
`default_nettype wire

// ---- loader_link_map.svh ----
/*
 * Constants for the serial loader front end: byte codes, sync pattern
 * counts and rate limits.
 * Assumes inclusion by the design file only.
 */
`ifndef LOADER_LINK_MAP_SVH
`define LOADER_LINK_MAP_SVH

`define LL_ACK_BYTE 8'hCC
`define LL_NAK_BYTE 8'h33
`define LL_PAD_BYTE 8'h00
`define LL_LEN_MIN 8'h02
`define LL_SYNC_LAST 4'h8
`define LL_DIV_MSB 19
`define LL_DIV_LSB 4
`define LL_CNT_OVF 20
`define LL_MIN_DIV 16'h0010
`define LL_TX_BITS 4'h9
`define LL_LAST_BIT 3'h7

`endif

// ---- loader_link_pkg.sv ----
/*
 * Types shared by the serial loader front end.
 * Assumes the constant map header is on the include path.
 */
`default_nettype none
package loader_link_pkg;
	typedef enum logic [1:0] {LINK_NONE, LINK_ASYNC, LINK_SYNC} link_t;
	typedef enum {A_MEASURE, A_SKIP, A_IDLE, A_START, A_DATA, A_STOP} async_t;
	typedef enum {P_PAD, P_SUM, P_DATA} pkt_t;
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} beat_t;
endpackage : loader_link_pkg
`default_nettype wire

// ---- loader_host_model.sv ----
/*
 * Host model for the serial loader front end: async sender and receiver,
 * sync serial master in clock polarity one, clock phase one.
 * Assumes clk_sys is the loader crystal clock and paces every host action.
 */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side of both serial links
// ****************************************
module loader_host_model (
	input wire logic clk_sys, // crystal clock
	output var logic uartRx, // host async out
	input wire logic uartTx, // device async out
	output var logic ssiClk, // host sync clock
	output var logic ssiFss_n, // frame select, low
	output var logic ssiMosi, // host sync data
	input wire logic ssiMiso, // device sync data
	input wire logic ssiMisoOe // device miso enable
);
	localparam int SSI_HALF = 6; // half period, clock over twelve overall
	// idle levels at time zero
	initial begin
		uartRx = 1'b1;
		ssiClk = 1'b1;
		ssiFss_n = 1'b1;
		ssiMosi = 1'b0;
	end
	// wait cycles, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	// one character: start, eight data lsb first, one stop
	task automatic uart_send(input int d, input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		tick(1);
		for (int i = 0; i < 10; i++) begin
			uartRx = frame[i];
			tick(d);
		end
	endtask : uart_send
	// rate pattern: two 0x55 characters
	task automatic sync_pattern(input int d);
		uart_send(d, 8'h55);
		uart_send(d, 8'h55);
	endtask : sync_pattern
	// bounded wait for one character from the device
	task automatic uart_recv(input int d, input int limit, output logic [7:0] b, output bit ok);
		int n;
		ok = 1'b0;
		b = 8'h00;
		// look one step past each edge, where the line has settled
		for (n = 0; n < limit && uartTx !== 1'b0; n++) tick(1);
		if (uartTx !== 1'b0) return;
		tick(d / 2);
		if (uartTx !== 1'b0) return;
		for (int i = 0; i < 8; i++) begin
			tick(d);
			b[i] = uartTx;
		end
		tick(d);
		ok = (uartTx === 1'b1);
	endtask : uart_recv
	// frame select on or off
	task automatic ssi_frame(input logic sel);
		ssiFss_n = !sel;
		tick(SSI_HALF);
	endtask : ssi_frame
	// one byte as master: change on fall, sample on rise, msb first
	task automatic ssi_xfer(input logic [7:0] tx, output logic [7:0] rx, output bit oe);
		rx = 8'h00;
		oe = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			ssiClk = 1'b0;
			ssiMosi = tx[i];
			tick(SSI_HALF);
			rx[i] = ssiMisoOe ? ssiMiso : ~rx[(i + 1) % 8];
			oe |= ssiMisoOe;
			ssiClk = 1'b1;
			tick(SSI_HALF);
		end
		tick(SSI_HALF);
	endtask : ssi_xfer
endmodule : loader_host_model
`default_nettype wire

// ---- serial_boot_loader_link_tb.sv ----
/*
 * Self-checking bench for the serial loader front end.
 * Assumes the package, map header and host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench top
// ****************************************
module serial_boot_loader_link_tb;
	localparam int BIT_CYC = 40; // host bit time, slower than clock over 32
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	wire logic uartRx, uartTx, ssiClk, ssiFss_n, ssiMosi, ssiMiso, ssiMisoOe;
	loader_link_pkg::link_t linkSel;
	logic [15:0] rateDivisor;
	loader_link_pkg::beat_t dataOut;
	wire logic pktDone, pktGood;
	int mismatches = 0;
	int tests_run = 0;
	int beats = 0;
	int dones = 0;
	logic [7:0] lastData;
	logic lastFlag;
	// clock, 8 ns
	always #4 clk_sys = ~clk_sys;
	serial_boot_loader_link dut (.clk_sys(clk_sys), .rst(rst), .uartRx(uartRx),
		.uartTx(uartTx), .ssiClk(ssiClk), .ssiFss_n(ssiFss_n), .ssiMosi(ssiMosi),
		.ssiMiso(ssiMiso), .ssiMisoOe(ssiMisoOe), .linkSel(linkSel),
		.rateDivisor(rateDivisor), .dataOut(dataOut), .pktDone(pktDone), .pktGood(pktGood));
	loader_host_model host (.clk_sys(clk_sys), .uartRx(uartRx), .uartTx(uartTx),
		.ssiClk(ssiClk), .ssiFss_n(ssiFss_n), .ssiMosi(ssiMosi), .ssiMiso(ssiMiso),
		.ssiMisoOe(ssiMisoOe));
	// data beat and packet end monitor, mid cycle where outputs are settled
	always @(negedge clk_sys) begin
		if (dataOut.valid === 1'b1) begin
			beats++;
			lastData = dataOut.data;
		end
		if (pktDone === 1'b1) begin
			dones++;
			lastFlag = dataOut.last;
		end
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input bit ok, input string what);
		tests_run++;
		if (!ok) begin
			mismatches++;
			$display("ERROR at %0t: %s", $time, what);
		end
	endtask : check
	task automatic do_reset();
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
	endtask : do_reset
	// send one packet on either port and judge reply and data beats
	task automatic pkt(input bit viaSync, input logic [7:0] p[$], input logic [7:0] reply,
		input logic good, input int nData);
		logic [7:0] b;
		bit ok;
		int beats0;
		int dones0;
		beats0 = beats;
		dones0 = dones;
		lastFlag = 1'b0;
		if (viaSync) begin
			foreach (p[i]) host.ssi_xfer(p[i], b, ok);
			host.ssi_xfer(8'h00, b, ok);
			if (b === 8'h00) host.ssi_xfer(8'h00, b, ok);
		end else fork
			foreach (p[i]) host.uart_send(BIT_CYC, p[i]);
			host.uart_recv(BIT_CYC, 20000, b, ok);
		join
		check(ok && b === reply && pktGood === good, "packet reply");
		check(beats - beats0 == nData && dones - dones0 == 1 && (nData == 0
			|| (lastData === p[p.size() - 1] && lastFlag === 1'b1)), "packet data");
		if (!ok) give_verdict();
	endtask : pkt
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		do_reset();
		check(linkSel === loader_link_pkg::LINK_NONE && rateDivisor === 16'h0000
			&& uartTx === 1'b1 && ssiMisoOe === 1'b0 && pktDone === 1'b0, "reset state");
	endtask : t_reset
	task automatic t_rate_refused();
		logic [7:0] b;
		bit ok;
		fork
			host.sync_pattern(15);
			host.uart_recv(15, 800, b, ok);
		join
		check(!ok && linkSel === loader_link_pkg::LINK_NONE && rateDivisor === 16'h0000,
			"too fast rate accepted");
	endtask : t_rate_refused
	task automatic t_async();
		logic [7:0] b;
		bit ok;
		do_reset();
		fork
			host.sync_pattern(BIT_CYC);
			host.uart_recv(BIT_CYC, 2000, b, ok);
		join
		check(ok && b === 8'hCC, "no rate ack");
		if (!ok) give_verdict();
		check(linkSel === loader_link_pkg::LINK_ASYNC && rateDivisor === 16'(BIT_CYC),
			"async lock or divisor");
		pkt(1'b0, '{8'h00, 8'h03, 8'h20, 8'h20}, 8'hCC, 1'b1, 1);
		pkt(1'b0, '{8'h03, 8'h21, 8'h20}, 8'h33, 1'b0, 1);
		pkt(1'b0, '{8'h02, 8'h00}, 8'hCC, 1'b1, 0);
		pkt(1'b0, '{8'h01}, 8'h33, 1'b0, 0);
		host.ssi_frame(1'b1);
		host.ssi_xfer(8'h03, b, ok);
		host.ssi_frame(1'b0);
		check(!ok && linkSel === loader_link_pkg::LINK_ASYNC, "sync port answered");
	endtask : t_async
	task automatic t_sync();
		logic [7:0] b;
		bit ok;
		do_reset();
		host.ssi_frame(1'b1);
		pkt(1'b1, '{8'h00, 8'h03, 8'h20, 8'h20}, 8'hCC, 1'b1, 1);
		pkt(1'b1, '{8'h04, 8'h31, 8'h20, 8'h10}, 8'h33, 1'b0, 2);
		host.ssi_frame(1'b0);
		check(linkSel === loader_link_pkg::LINK_SYNC, "sync lock");
		fork
			host.sync_pattern(BIT_CYC);
			host.uart_recv(BIT_CYC, 2000, b, ok);
		join
		check(!ok && linkSel === loader_link_pkg::LINK_SYNC && rateDivisor === 16'h0000,
			"async port answered");
	endtask : t_sync
	// main sequence
	initial begin
		t_reset();
		t_rate_refused();
		t_async();
		t_sync();
		give_verdict();
	end
endmodule : serial_boot_loader_link_tb
`default_nettype wire
